// *** rtl/activity_monitor_map.vh ***
// offsets, fields, encodings and reset values of the activity monitor register bank
`ifndef ACTIVITY_MONITOR_MAP_VH
`define ACTIVITY_MONITOR_MAP_VH

// ----------------------------------------
// external debug offsets
// ----------------------------------------
`define AM_OFS_GROUP_SIZES 12'hCE0
`define AM_OFS_CONFIG 12'hE00
`define AM_OFS_ARCH_ENABLE_SET 12'hC00
`define AM_OFS_AUX_ENABLE_SET 12'hC04
`define AM_OFS_ARCH_ENABLE_CLEAR 12'hC20
`define AM_OFS_AUX_ENABLE_CLEAR 12'hC24

// ----------------------------------------
// system register encodings {op0,op1,crn,crm,op2}
// ----------------------------------------
`define AM_ENC_CONFIG 16'hDE41
`define AM_ENC_GROUP_SIZES 16'hDE42
`define AM_ENC_ARCH_ENABLE_CLEAR 16'hDE44
`define AM_ENC_ARCH_ENABLE_SET 16'hDE45
`define AM_ENC_AUX_ENABLE_CLEAR 16'hDE48
`define AM_ENC_AUX_ENABLE_SET 16'hDE49

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define AM_CFG_GROUPS_VAL 4'h1
`define AM_CFG_HALT_ON_DEBUG_SUPPORT_BIT 24
`define AM_CFG_SIZE_VAL 6'h3F
`define AM_CFG_COUNT_VAL 8'h06
`define AM_CGC_AUX_VAL 8'h03
`define AM_CGC_ARCH_VAL 8'h04
`define AM_CONFIG_RESET 32'h11003F06
`define AM_GROUP_SIZES_RESET 32'h00000304

// ----------------------------------------
// event type reset values
// ----------------------------------------
`define AM_ARCH_TYPE0_RESET 32'h00000011
`define AM_ARCH_TYPE1_RESET 32'h00004004
`define AM_ARCH_TYPE2_RESET 32'h00000008
`define AM_ARCH_TYPE3_RESET 32'h00004005
`define AM_AUX_TYPE0_RESET 32'h00000300
`define AM_AUX_TYPE1_RESET 32'h00000301
`define AM_AUX_TYPE2_RESET 32'h00000302
`define AM_ZERO32 32'h00000000

// ----------------------------------------
// trap control
// ----------------------------------------
`define AM_TRAP_BIT 30

`endif

// *** rtl/activity_counter_bank.v ***
// bank of 64-bit activity counters with per-counter enables
`default_nettype none
module activity_counter_bank #(
    parameter N = 4,
    parameter W = 64
) (
    // clock and reset
    input wire ref_clk_in,
    input wire srst_in,
    // count control
    input wire [N-1:0] enable_in,
    input wire [N-1:0] event_in,
    // counter values
    output wire [N*W-1:0] count_out
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gen_cnt
            // one register per counter, so each has a single driving process
            reg [W-1:0] cnt;
            always @(posedge ref_clk_in) begin
                if (srst_in) begin
                    cnt <= {W{1'b0}};
                end else if (enable_in[g] && event_in[g]) begin
                    cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
                end
            end
            assign count_out[g*W +: W] = cnt;
        end
    endgenerate
endmodule
`default_nettype wire

// *** rtl/activity_monitor_config_regs.v ***
// activity monitor identification registers, reset bank and access traps
// Operation
// - configuration register reads fixed 0x11003F06 after reset
// - bits 31:28 report group count minus one, value one
// - bit 24 reads one: halt-on-debug supported
// - bits 13:8 read all ones: largest counter 64 bits
// - bits 7:0 read six: counter count minus one
// - group sizes bits 15:8 report three auxiliary counters
// - group sizes bits 7:0 report four architected counters
// - group sizes register resets to 0x00000304
// - four 64-bit architected counters cleared by reset
// - three 64-bit auxiliary counters cleared by reset
// - four architected event types reset to printed selections
// - three auxiliary event types reset to printed selections
// - enable set and clear views reset to zero, counters disabled
// - monitor control and user access enable reset to zero
// - encoding 3,3,c12,c8,1 reads configuration register
// - encoding 3,3,c12,c8,2 reads group sizes register
// - configuration register read-only at debug offset 0xE00
// - group sizes register read-only at debug offset 0xCE0
// - top-level trap bit 30 traps levels 0 to 2 to top level
// - hypervisor trap bit 30 traps non-secure levels 0,1 to hypervisor when top-level bit 30 is clear
`include "activity_monitor_map.vh"
`default_nettype none
module activity_monitor_config_regs #(
    parameter ARCH_N = 4,
    parameter AUX_N = 3,
    parameter CNT_W = 64
) (
    // clock and reset
    input wire ref_clk_in,
    input wire srst_in,
    // system register read port
    input wire sys_read_in,
    input wire [15:0] sys_encoding_in,
    input wire [1:0] sys_el_in,
    input wire sys_nonsecure_in,
    output reg sys_valid_out,
    output reg [63:0] sys_rdata_out,
    output reg sys_trap_top_out,
    output reg sys_trap_hyp_out,
    output reg sys_undef_out,
    // trap control bits from the auxiliary control registers
    input wire [31:0] top_level_aux_control_in,
    input wire [31:0] hyp_level_aux_control_in,
    // external debug read-only port
    input wire dbg_read_in,
    input wire dbg_write_in,
    input wire [11:0] dbg_addr_in,
    output reg dbg_valid_out,
    output reg [31:0] dbg_rdata_out,
    // counted events
    input wire [ARCH_N-1:0] arch_event_in,
    input wire [AUX_N-1:0] aux_event_in,
    // enable state
    output reg [ARCH_N-1:0] arch_enable_out,
    output reg [AUX_N-1:0] aux_enable_out
);
    // ----------------------------------------
    // fixed identification values
    // ----------------------------------------
    wire [31:0] monitor_configuration;
    wire [31:0] counter_group_sizes;
    assign monitor_configuration = {`AM_CFG_GROUPS_VAL, 3'h0, 1'b1, 10'h000,
                                    `AM_CFG_SIZE_VAL, `AM_CFG_COUNT_VAL};
    assign counter_group_sizes = {16'h0000, `AM_CGC_AUX_VAL, `AM_CGC_ARCH_VAL};

    // ----------------------------------------
    // reset-held bank state
    // ----------------------------------------
    reg [31:0] arch_event_type [0:ARCH_N-1];
    reg [31:0] aux_event_type [0:AUX_N-1];
    reg [31:0] monitor_control;
    reg [31:0] user_access_enable;
    integer i;

    function [31:0] arch_type_reset;
        input integer idx;
        begin
            case (idx)
                0: arch_type_reset = `AM_ARCH_TYPE0_RESET;
                1: arch_type_reset = `AM_ARCH_TYPE1_RESET;
                2: arch_type_reset = `AM_ARCH_TYPE2_RESET;
                default: arch_type_reset = `AM_ARCH_TYPE3_RESET;
            endcase
        end
    endfunction

    function [31:0] aux_type_reset;
        input integer idx;
        begin
            case (idx)
                0: aux_type_reset = `AM_AUX_TYPE0_RESET;
                1: aux_type_reset = `AM_AUX_TYPE1_RESET;
                default: aux_type_reset = `AM_AUX_TYPE2_RESET;
            endcase
        end
    endfunction

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            for (i = 0; i < ARCH_N; i = i + 1) begin
                arch_event_type[i] <= arch_type_reset(i);
            end
            for (i = 0; i < AUX_N; i = i + 1) begin
                aux_event_type[i] <= aux_type_reset(i);
            end
            monitor_control <= `AM_ZERO32;
            user_access_enable <= `AM_ZERO32;
            arch_enable_out <= {ARCH_N{1'b0}};
            aux_enable_out <= {AUX_N{1'b0}};
        end
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    wire [ARCH_N*CNT_W-1:0] arch_counts;
    wire [AUX_N*CNT_W-1:0] aux_counts;

    activity_counter_bank #(.N(ARCH_N), .W(CNT_W)) u_arch_cnt (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .enable_in(arch_enable_out),
        .event_in(arch_event_in),
        .count_out(arch_counts)
    );

    activity_counter_bank #(.N(AUX_N), .W(CNT_W)) u_aux_cnt (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .enable_in(aux_enable_out),
        .event_in(aux_event_in),
        .count_out(aux_counts)
    );

    // ----------------------------------------
    // system register reads and traps
    // ----------------------------------------
    wire trap_top;
    wire trap_hyp;
    assign trap_top = top_level_aux_control_in[`AM_TRAP_BIT] && (sys_el_in != 2'd3);
    assign trap_hyp = hyp_level_aux_control_in[`AM_TRAP_BIT] && sys_nonsecure_in &&
                      (sys_el_in < 2'd2);

    reg [63:0] next_sys_rdata;
    reg next_sys_hit;
    always @* begin
        next_sys_rdata = 64'h0000000000000000;
        next_sys_hit = 1'b1;
        case (sys_encoding_in)
            `AM_ENC_CONFIG: next_sys_rdata = {32'h0, monitor_configuration};
            `AM_ENC_GROUP_SIZES: next_sys_rdata = {32'h0, counter_group_sizes};
            `AM_ENC_ARCH_ENABLE_SET: next_sys_rdata[ARCH_N-1:0] = arch_enable_out;
            `AM_ENC_ARCH_ENABLE_CLEAR: next_sys_rdata[ARCH_N-1:0] = arch_enable_out;
            `AM_ENC_AUX_ENABLE_SET: next_sys_rdata[AUX_N-1:0] = aux_enable_out;
            `AM_ENC_AUX_ENABLE_CLEAR: next_sys_rdata[AUX_N-1:0] = aux_enable_out;
            default: next_sys_hit = 1'b0;
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            sys_valid_out <= 1'b0;
            sys_rdata_out <= 64'h0000000000000000;
            sys_trap_top_out <= 1'b0;
            sys_trap_hyp_out <= 1'b0;
            sys_undef_out <= 1'b0;
        end else begin
            sys_valid_out <= sys_read_in;
            sys_trap_top_out <= sys_read_in && trap_top;
            sys_trap_hyp_out <= sys_read_in && !trap_top && trap_hyp;
            sys_undef_out <= sys_read_in && !trap_top && !trap_hyp && !next_sys_hit;
            if (sys_read_in && !trap_top && !trap_hyp) begin
                sys_rdata_out <= next_sys_rdata;
            end else begin
                sys_rdata_out <= 64'h0000000000000000;
            end
        end
    end

    // ----------------------------------------
    // external debug reads, writes ignored
    // ----------------------------------------
    reg [31:0] next_dbg_rdata;
    always @* begin
        next_dbg_rdata = `AM_ZERO32;
        case (dbg_addr_in)
            `AM_OFS_CONFIG: next_dbg_rdata = monitor_configuration;
            `AM_OFS_GROUP_SIZES: next_dbg_rdata = counter_group_sizes;
            `AM_OFS_ARCH_ENABLE_SET: next_dbg_rdata[ARCH_N-1:0] = arch_enable_out;
            `AM_OFS_ARCH_ENABLE_CLEAR: next_dbg_rdata[ARCH_N-1:0] = arch_enable_out;
            `AM_OFS_AUX_ENABLE_SET: next_dbg_rdata[AUX_N-1:0] = aux_enable_out;
            `AM_OFS_AUX_ENABLE_CLEAR: next_dbg_rdata[AUX_N-1:0] = aux_enable_out;
            default: next_dbg_rdata = `AM_ZERO32;
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            dbg_valid_out <= 1'b0;
            dbg_rdata_out <= `AM_ZERO32;
        end else begin
            // writes complete but change nothing
            dbg_valid_out <= dbg_read_in || dbg_write_in;
            dbg_rdata_out <= dbg_read_in ? next_dbg_rdata : `AM_ZERO32;
        end
    end
endmodule
`default_nettype wire

// *** sim/config_regs_checker_assertions.sv ***
// concurrent checks on the identification register ports
`default_nettype none
module config_regs_checker (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // system register port
    input wire logic sys_read_in,
    input wire logic [15:0] sys_encoding_in,
    input wire logic [1:0] sys_el_in,
    input wire logic sys_nonsecure_in,
    input wire logic sys_valid_out,
    input wire logic [63:0] sys_rdata_out,
    input wire logic sys_trap_top_out,
    input wire logic sys_trap_hyp_out,
    input wire logic [31:0] top_level_aux_control_in,
    input wire logic [31:0] hyp_level_aux_control_in,
    // debug port
    input wire logic dbg_read_in,
    input wire logic dbg_write_in,
    input wire logic [11:0] dbg_addr_in,
    input wire logic dbg_valid_out,
    input wire logic [31:0] dbg_rdata_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    wire logic top_trap = top_level_aux_control_in[30] && sys_el_in != 2'd3;
    wire logic hyp_trap = !top_trap && hyp_level_aux_control_in[30] && sys_nonsecure_in
        && sys_el_in < 2'd2;
    sequence s_plain_read(logic [15:0] e);
        sys_read_in && sys_encoding_in == e && !top_trap && !hyp_trap;
    endsequence
    sequence s_answer(logic [31:0] v);
        sys_valid_out && sys_rdata_out == {32'h0, v};
    endsequence
    chk_config_read: assert property (s_plain_read(16'hDE41) |=> s_answer(32'h11003F06))
        else $error("configuration read wrong");
    chk_group_read: assert property (s_plain_read(16'hDE42) |=> s_answer(32'h00000304))
        else $error("group size read wrong");
    chk_top_trap: assert property (sys_read_in && top_trap |=>
        sys_trap_top_out && !sys_trap_hyp_out && sys_rdata_out == 64'h0)
        else $error("top level trap wrong");
    chk_hyp_trap: assert property (sys_read_in && hyp_trap |=>
        sys_trap_hyp_out && !sys_trap_top_out && sys_rdata_out == 64'h0)
        else $error("hypervisor trap wrong");
    chk_no_trap: assert property (s_plain_read(sys_encoding_in) |=>
        !sys_trap_top_out && !sys_trap_hyp_out)
        else $error("spurious trap");
    chk_debug_config: assert property (dbg_read_in && dbg_addr_in == 12'hE00 |=>
        dbg_valid_out && dbg_rdata_out == 32'h11003F06)
        else $error("debug configuration read wrong");
    chk_debug_groups: assert property (dbg_read_in && dbg_addr_in == 12'hCE0 |=>
        dbg_valid_out && dbg_rdata_out == 32'h00000304)
        else $error("debug group size read wrong");
    chk_debug_write: assert property (dbg_write_in && !dbg_read_in |=>
        dbg_valid_out && dbg_rdata_out == 32'h0)
        else $error("debug write not ignored");
endmodule
bind activity_monitor_config_regs config_regs_checker config_regs_checker_inst (.*);
`default_nettype wire

// *** sim/core_requester.sv ***
// request model for core software and the external debugger
`default_nettype none
module core_requester (
    // clock
    input wire logic ref_clk_in,
    // system register request
    output logic sys_read_in,
    output logic [15:0] sys_encoding_in,
    output logic [1:0] sys_el_in,
    output logic sys_nonsecure_in,
    output logic [31:0] top_level_aux_control_in,
    output logic [31:0] hyp_level_aux_control_in,
    // debug request
    output logic dbg_read_in,
    output logic dbg_write_in,
    output logic [11:0] dbg_addr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {sys_read_in, sys_encoding_in, sys_el_in, sys_nonsecure_in} = '0;
    initial {top_level_aux_control_in, hyp_level_aux_control_in} = '0;
    initial {dbg_read_in, dbg_write_in, dbg_addr_in} = '0;
    // one request per edge, software only reads
    task sys_rd(input logic [15:0] e, input logic [1:0] el, input logic ns, tb, hb);
        @(posedge ref_clk_in);
        {dbg_read_in, dbg_write_in} <= 2'b00;
        sys_read_in <= 1'b1;
        sys_encoding_in <= e;
        sys_el_in <= el;
        sys_nonsecure_in <= ns;
        top_level_aux_control_in <= {1'b0, tb, 30'h0};
        hyp_level_aux_control_in <= {1'b0, hb, 30'h0};
    endtask
    task dbg_rd(input logic [11:0] a, input logic wr);
        @(posedge ref_clk_in);
        sys_read_in <= 1'b0;
        dbg_read_in <= !wr;
        dbg_write_in <= wr;
        dbg_addr_in <= a;
    endtask
    // released lines do not keep their last value
    task idle;
        @(posedge ref_clk_in);
        {sys_read_in, dbg_read_in, dbg_write_in} <= 3'b000;
        sys_encoding_in <= ~sys_encoding_in;
        dbg_addr_in <= ~dbg_addr_in;
    endtask
endmodule
`default_nettype wire

// *** sim/test_activity_monitor_config_regs.sv ***
// self-checking bench of the activity monitor identification registers
`default_nettype none
module test_activity_monitor_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CFG = {4'h1, 3'h0, 1'b1, 10'h0, 6'h3F, 8'h06};
    localparam logic [31:0] GRP = {16'h0, 8'h03, 8'h04};
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] arch_event_in = '0;
    logic [2:0] aux_event_in = '0;
    wire logic sys_read_in, sys_nonsecure_in, dbg_read_in, dbg_write_in;
    wire logic [15:0] sys_encoding_in;
    wire logic [1:0] sys_el_in;
    wire logic [31:0] top_level_aux_control_in, hyp_level_aux_control_in;
    wire logic [11:0] dbg_addr_in;
    logic sys_valid_out, sys_trap_top_out, sys_trap_hyp_out, sys_undef_out, dbg_valid_out;
    logic [63:0] sys_rdata_out;
    logic [31:0] dbg_rdata_out;
    logic [3:0] arch_enable_out;
    logic [2:0] aux_enable_out;
    logic [66:0] sys_q[$];
    logic [31:0] dbg_q[$];
    logic [15:0] encs[7] = '{16'hDE41, 16'hDE42, 16'hDE44, 16'hDE45, 16'hDE48, 16'hDE49, 16'h0};
    logic [11:0] adrs[7] = '{12'hE00, 12'hCE0, 12'hC00, 12'hC04, 12'hC20, 12'hC24, 12'h004};
    int n_fail = 0;
    int n_compared = 0;
    activity_monitor_config_regs activity_monitor_config_regs_inst (.*);
    core_requester core_requester_inst (.*);
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        arch_event_in <= 4'($urandom);
        aux_event_in <= 3'($urandom);
    end
    task check(input logic [66:0] seen, input logic [66:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [66:0] exp_sys(input logic [15:0] e, input logic [1:0] el,
                                           input logic ns, tb, hb);
        if (tb && el != 2'd3) return {3'b010, 64'h0};
        if (hb && ns && el < 2'd2) return {3'b001, 64'h0};
        if (e == 16'hDE41) return {35'h0, CFG};
        if (e == 16'hDE42) return {35'h0, GRP};
        return (e == 16'h0) ? {3'b100, 64'h0} : 67'h0;
    endfunction
    task sr(input logic [15:0] e, input logic [1:0] el, input logic ns, tb, hb);
        sys_q.push_back(exp_sys(e, el, ns, tb, hb));
        core_requester_inst.sys_rd(e, el, ns, tb, hb);
    endtask
    task dr(input logic [11:0] a, input logic wr);
        dbg_q.push_back(wr ? 32'h0 : a == 12'hE00 ? CFG : a == 12'hCE0 ? GRP : 32'h0);
        core_requester_inst.dbg_rd(a, wr);
    endtask
    always @(posedge ref_clk_in) begin
        if (sys_valid_out || sys_trap_top_out || sys_trap_hyp_out || sys_undef_out)
            check({sys_undef_out, sys_trap_top_out, sys_trap_hyp_out, sys_rdata_out},
                  sys_q.pop_front());
        if (dbg_valid_out) begin
            check({35'h0, dbg_rdata_out}, {35'h0, dbg_q.pop_front()});
            check({60'h0, arch_enable_out, aux_enable_out}, 67'h0);
        end
    end
    task print_verdict;
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'h1613));
        repeat (3) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 7; i++) sr(encs[i], 2'(i % 4), i[0], 1'b0, 1'b0);
        for (int i = 0; i < 32; i++) sr(16'hDE42, i[1:0], i[2], i[3], i[4]);
        repeat (24) sr(encs[$urandom % 6], 2'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
        foreach (adrs[i]) dr(adrs[i], 1'b0);
        dr(12'hE00, 1'b1);
        dr(12'hCE0, 1'b1);
        dr(12'hE00, 1'b0);
        dr(12'hCE0, 1'b0);
        repeat (3) core_requester_inst.idle();
        srst_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        sr(16'hDE41, 2'd3, 1'b0, 1'b1, 1'b1);
        dr(12'hE00, 1'b0);
        repeat (4) core_requester_inst.idle();
        print_verdict;
    end
endmodule
`default_nettype wire
